// ---- common/csb_defines.svh ----
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
// What this block does
// - Page codes 0 to 4 select pages 0 to 4 and codes 5, 6 and 7 all select page 5.
// - A jump, call or program counter write copies the page into the upper counter bits.
// - A return leaves the page field untouched so execution resumes in the caller's page.
// - Time-out bit 4 is set by sleep, watchdog clear and power-up, cleared by watchdog expiry.
// - Power-down bit 3 is set at power-on and by watchdog clear, cleared by sleep.
// - After wake or reset the time-out and power-down pair reads 00, 01, 10 or 11 per event.
// - Status holds zero in bit 2, half carry in bit 1 and carry in bit 0, all read and write.
// - Bank bits 7 to 6 pick special bank 0,1,0,0 and RAM bank 0,1,2,3 for codes 0 to 3.
// - The six low pointer bits address any of locations 00 to 3f indirectly.
// - Without indirect use the pointer register is a plain 8-bit read and write register.
// - Location 00 is not a register; accesses go to the location the pointer names.
// - Port 5 bit 0 selects the control page: 0 maps page 0, 1 maps page 1.
// - Port 5 bits 7 to 4 hold port data, bits 3 to 1 unused, direction from its control reg.
// - Ports 6, 7 and 8 each have an 8-bit data register with per-bit direction control.
// - 00-04 common, 05-0f special bank or control page, 10-1f general, 20-3f RAM bank.

// ==================================================
// Addresses
`define CSB_ADDR_INDIRECT 6'h00
`define CSB_ADDR_STATUS   6'h03
`define CSB_ADDR_POINTER  6'h04
`define CSB_ADDR_PORT5    6'h05
`define CSB_ADDR_PORT6    6'h06
`define CSB_ADDR_PORT7    6'h07
`define CSB_ADDR_PORT8    6'h08
`define CSB_COMMON_LAST   6'h04
`define CSB_SPECIAL_LAST  6'h0f
`define CSB_GENERAL_LAST  6'h1f
// ==================================================
// Fields
`define CSB_TIMEOUT_BIT   4
`define CSB_PWRDOWN_BIT   3
`define CSB_ZERO_BIT      2
`define CSB_HALF_BIT      1
`define CSB_CARRY_BIT     0
`define CSB_PAGE_MAX      3'h5
`define CSB_PORT5_MASK    8'hf1
// ==================================================
// Reset values
`define CSB_STATUS_RESET  8'h18
`define CSB_ZERO8         8'h00
`define CSB_PC_RESET      13'h0000
`endif

// ---- common/csb_pkg.sv ----
package csb_pkg;
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [5:0] addr;
    logic [7:0] wrData;
  } csb_access_type;

  typedef struct packed {
    logic       sleepInstr;
    logic       wdtClearInstr;
    logic       wdtTimeout;
    logic       extResetWake;
    logic       pcLoad;
    logic       ret;
  } csb_event_type;

  typedef struct packed {
    logic       zeroSet;
    logic       zeroVal;
    logic       halfSet;
    logic       halfVal;
    logic       carrySet;
    logic       carryVal;
  } csb_alu_type;

  typedef enum logic [1:0] {
    CSB_REGION_COMMON, CSB_REGION_SPECIAL, CSB_REGION_GENERAL, CSB_REGION_RAM
  } csb_region_type;

  typedef struct packed {
    csb_region_type region;
    logic           specialBank;
    logic           ctrlPage;
    logic [1:0]     ramBank;
    logic [5:0]     addr;
  } csb_decode_type;
endpackage

// ---- hdl/csb_addr_decode.sv ----
`timescale 1ns/1ps
`include "csb_defines.svh"
module csb_addr_decode import csb_pkg::*; (
  // Request
  input  wire logic [5:0]     rawAddr,
  input  wire logic [7:0]     pointer,
  input  wire logic           ctrlPage,
  // Result
  output csb_decode_type      decode
);
  logic [5:0] effAddr;
  always_comb begin
    // Location 00 is only a window onto the pointer
    effAddr = (rawAddr == `CSB_ADDR_INDIRECT) ? pointer[5:0] : rawAddr;
    decode.addr        = effAddr;
    decode.ctrlPage    = ctrlPage;
    decode.ramBank     = pointer[7:6];
    decode.specialBank = (pointer[7:6] == 2'b01);
    if (effAddr <= `CSB_COMMON_LAST) begin
      decode.region = CSB_REGION_COMMON;
    end else if (effAddr <= `CSB_SPECIAL_LAST) begin
      decode.region = CSB_REGION_SPECIAL;
    end else if (effAddr <= `CSB_GENERAL_LAST) begin
      decode.region = CSB_REGION_GENERAL;
    end else begin
      decode.region = CSB_REGION_RAM;
    end
  end
endmodule // csb_addr_decode

// ---- hdl/csb_core_status.sv ----
`timescale 1ns/1ps
`include "csb_defines.svh"
module csb_core_status import csb_pkg::*; (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Core register access
  input  csb_access_type      access,
  output logic [7:0]          rdData,
  output logic                rdHit,
  output csb_decode_type      decode,
  // Core events
  input  csb_event_type       events,
  input  csb_alu_type         alu,
  input  wire logic [9:0]     pcLow,
  output logic [12:0]         pcTarget,
  output logic [2:0]          romPage,
  // Port data
  input  wire logic [7:0]     portFiveIn,
  input  wire logic [7:0]     portSixIn,
  input  wire logic [7:0]     portSevenIn,
  input  wire logic [7:0]     portEightIn,
  output logic [7:0]          portFiveOut,
  output logic [7:0]          portSixOut,
  output logic [7:0]          portSevenOut,
  output logic [7:0]          portEightOut,
  // Direction control, 1 means input
  input  wire logic [7:0]     portFiveDirCtrl,
  input  wire logic [7:0]     portSixDirCtrl,
  input  wire logic [7:0]     portSevenDirCtrl,
  input  wire logic [7:0]     portEightDirCtrl
);
  // ==================================================
  // Registers
  logic [7:0]  status, next_status;
  logic [7:0]  pointer, next_pointer;
  logic [7:0]  port5, next_port5;
  logic [7:0]  port6, next_port6;
  logic [7:0]  port7, next_port7;
  logic [7:0]  port8, next_port8;
  logic [12:0] next_pcTarget;
  logic [7:0]  pinSync1 [4];
  logic [7:0]  pinSync2 [4];
  logic [7:0]  pinRaw [4];
  logic [7:0]  dirCtrl [4];
  logic [7:0]  latchVal [4];
  logic [7:0]  portRead [4];
  logic        wrHit;

  assign pinRaw   = '{portFiveIn, portSixIn, portSevenIn, portEightIn};
  assign dirCtrl  = '{portFiveDirCtrl, portSixDirCtrl, portSevenDirCtrl, portEightDirCtrl};
  assign latchVal = '{port5, port6, port7, port8};

  // ==================================================
  // Decode
  csb_addr_decode uDecode (
    .rawAddr  (access.addr),
    .pointer  (pointer),
    .ctrlPage (port5[0]),
    .decode   (decode)
  );

  // Decode checks beside the instance, so a slip in its wiring shows at once
  bankMap_a: assert property (@(posedge clk) disable iff (!nrst)
    decode.ramBank == pointer[7:6] && decode.specialBank == (pointer[7:6] == 2'b01))
    else $error("bank select map wrong");
  ramRegion_a: assert property (@(posedge clk) disable iff (!nrst)
    decode.addr >= 6'h20 |-> decode.region == CSB_REGION_RAM)
    else $error("ram region decode wrong");
  generalRegion_a: assert property (@(posedge clk) disable iff (!nrst)
    decode.addr >= 6'h10 && decode.addr <= 6'h1f |-> decode.region == CSB_REGION_GENERAL)
    else $error("general region decode wrong");
  pagePassed_a: assert property (@(posedge clk) disable iff (!nrst)
    decode.ctrlPage == port5[0])
    else $error("control page not passed on");

  // Pins come from outside, so two flops before any read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinSync1 <= '{default: `CSB_ZERO8};
      pinSync2 <= '{default: `CSB_ZERO8};
    end else begin
      pinSync1 <= pinRaw;
      pinSync2 <= pinSync1;
    end
  end

  // Input bits read the pin, output bits read the latch
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gPortRead
      assign portRead[g] = (dirCtrl[g] & pinSync2[g]) | (~dirCtrl[g] & latchVal[g]);
    end
  endgenerate

  // ==================================================
  // Register write path
  always_comb begin
    wrHit        = access.wrEn && (decode.region == CSB_REGION_COMMON ||
                   (decode.region == CSB_REGION_SPECIAL && !decode.specialBank));
    next_status  = status;
    next_pointer = pointer;
    next_port5   = port5;
    next_port6   = port6;
    next_port7   = port7;
    next_port8   = port8;
    if (wrHit) begin
      unique case (decode.addr)
        `CSB_ADDR_STATUS:  next_status  = access.wrData;
        `CSB_ADDR_POINTER: next_pointer = access.wrData;
        `CSB_ADDR_PORT5:   next_port5   = access.wrData & `CSB_PORT5_MASK;
        `CSB_ADDR_PORT6:   next_port6   = access.wrData;
        `CSB_ADDR_PORT7:   next_port7   = access.wrData;
        `CSB_ADDR_PORT8:   next_port8   = access.wrData;
        default: ;
      endcase
    end
    // Flag updates from the datapath beat a plain write in the same cycle
    if (alu.zeroSet) begin
      next_status[`CSB_ZERO_BIT] = alu.zeroVal;
    end
    if (alu.halfSet) begin
      next_status[`CSB_HALF_BIT] = alu.halfVal;
    end
    if (alu.carrySet) begin
      next_status[`CSB_CARRY_BIT] = alu.carryVal;
    end
    // Hardware events win over software writes of the flag pair
    if (events.wdtClearInstr) begin
      next_status[`CSB_TIMEOUT_BIT] = 1'b1;
      next_status[`CSB_PWRDOWN_BIT] = 1'b1;
    end else if (events.sleepInstr) begin
      next_status[`CSB_TIMEOUT_BIT] = 1'b1;
      next_status[`CSB_PWRDOWN_BIT] = 1'b0;
    end
    if (events.wdtTimeout) begin
      // Pair 00 from sleep, 01 when running
      next_status[`CSB_TIMEOUT_BIT] = 1'b0;
    end else if (events.extResetWake) begin
      // Pair 10: reset pin pulled while asleep
      next_status[`CSB_TIMEOUT_BIT] = 1'b1;
      next_status[`CSB_PWRDOWN_BIT] = 1'b0;
    end
  end

  // Status write check only in quiet cycles, so strobes cannot mask a lost write
  sequence sQuiet;
    events == '0 && alu == '0;
  endsequence

  sequence sStatusWrite;
    access.wrEn && decode.addr == `CSB_ADDR_STATUS ##0 sQuiet;
  endsequence

  sequence sPortFiveWrite;
    access.wrEn && decode.addr == `CSB_ADDR_PORT5 && !decode.specialBank;
  endsequence

  sequence sHiddenWrite;
    access.wrEn && decode.specialBank && decode.region == CSB_REGION_SPECIAL;
  endsequence

  statusWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    sStatusWrite |=> status == $past(access.wrData))
    else $error("status write lost");
  pointerWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    access.wrEn && decode.addr == `CSB_ADDR_POINTER |=> pointer == $past(access.wrData))
    else $error("pointer write lost");
  portFiveWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    sPortFiveWrite |=> port5 == ($past(access.wrData) & `CSB_PORT5_MASK))
    else $error("port 5 write wrong");
  portSixWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    access.wrEn && decode.addr == `CSB_ADDR_PORT6 && !decode.specialBank
    |=> port6 == $past(access.wrData))
    else $error("port 6 write lost");
  portEightWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    access.wrEn && decode.addr == `CSB_ADDR_PORT8 && !decode.specialBank
    |=> port8 == $past(access.wrData))
    else $error("port 8 write lost");
  hiddenWrite_a: assert property (@(posedge clk) disable iff (!nrst)
    sHiddenWrite |=> $stable({port5, port6, port7, port8}))
    else $error("bank 1 write reached a port");
  zeroFlag_a: assert property (@(posedge clk) disable iff (!nrst)
    alu.zeroSet |=> status[`CSB_ZERO_BIT] == $past(alu.zeroVal))
    else $error("zero flag wrong");
  halfFlag_a: assert property (@(posedge clk) disable iff (!nrst)
    alu.halfSet |=> status[`CSB_HALF_BIT] == $past(alu.halfVal))
    else $error("half carry flag wrong");
  resetWake_a: assert property (@(posedge clk) disable iff (!nrst)
    events.extResetWake && !events.wdtTimeout |=> status[4:3] == 2'b10)
    else $error("reset wake flags wrong");

  // Power-up and reset pin give pair 11
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status  <= `CSB_STATUS_RESET;
      pointer <= `CSB_ZERO8;
      port5   <= `CSB_ZERO8;
      port6   <= `CSB_ZERO8;
      port7   <= `CSB_ZERO8;
      port8   <= `CSB_ZERO8;
    end else begin
      status  <= next_status;
      pointer <= next_pointer;
      port5   <= next_port5;
      port6   <= next_port6;
      port7   <= next_port7;
      port8   <= next_port8;
    end
  end

  // ==================================================
  // Page select and program counter
  always_comb begin
    // Codes above four fold onto the last page
    romPage = (status[7:5] > `CSB_PAGE_MAX) ? `CSB_PAGE_MAX : status[7:5];
    next_pcTarget = pcTarget;
    // Returns restore from the stack and never touch the page
    if (events.pcLoad && !events.ret) begin
      next_pcTarget = {romPage, pcLow};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcTarget <= `CSB_PC_RESET;
    end else begin
      pcTarget <= next_pcTarget;
    end
  end

  retPage_a: assert property (@(posedge clk) disable iff (!nrst)
    events.ret && !access.wrEn |=> $stable(status[7:5]))
    else $error("return moved the page");

  // ==================================================
  // Read path
  always_comb begin
    rdData = `CSB_ZERO8;
    rdHit  = 1'b0;
    if (access.rdEn && (decode.region == CSB_REGION_COMMON ||
        (decode.region == CSB_REGION_SPECIAL && !decode.specialBank))) begin
      rdHit = 1'b1;
      unique case (decode.addr)
        `CSB_ADDR_STATUS:  rdData = status;
        `CSB_ADDR_POINTER: rdData = pointer;
        `CSB_ADDR_PORT5:   rdData = portRead[0] & `CSB_PORT5_MASK;
        `CSB_ADDR_PORT6:   rdData = portRead[1];
        `CSB_ADDR_PORT7:   rdData = portRead[2];
        `CSB_ADDR_PORT8:   rdData = portRead[3];
        default:           rdHit  = 1'b0;
      endcase
    end
  end

  assign portFiveOut  = port5;
  assign portSixOut   = port6;
  assign portSevenOut = port7;
  assign portEightOut = port8;

  // Read path checks
  pointerRead_a: assert property (@(posedge clk) disable iff (!nrst)
    access.rdEn && decode.addr == `CSB_ADDR_POINTER |-> rdHit && rdData == pointer)
    else $error("pointer read wrong");
  ramMiss_a: assert property (@(posedge clk) disable iff (!nrst)
    access.rdEn && decode.region == CSB_REGION_RAM |-> !rdHit && rdData == `CSB_ZERO8)
    else $error("ram read hit this block");
  pinInput_a: assert property (@(posedge clk) disable iff (!nrst)
    access.rdEn && decode.addr == `CSB_ADDR_PORT6 && !decode.specialBank
    && portSixDirCtrl == 8'hff |-> rdData == pinSync2[1])
    else $error("input pin not read");

  // ==================================================
  // Checks
  sequence sWdtClear;
    events.wdtClearInstr && !events.wdtTimeout && !events.extResetWake;
  endsequence

  pageFold_a: assert property (@(posedge clk) disable iff (!nrst)
    status[7:5] >= 3'h5 |-> romPage == 3'h5)
    else $error("page fold wrong");
  pcLoad_a: assert property (@(posedge clk) disable iff (!nrst)
    events.pcLoad && !events.ret |=> pcTarget == {$past(romPage), $past(pcLow)})
    else $error("pc load page wrong");
  retHold_a: assert property (@(posedge clk) disable iff (!nrst)
    events.ret |=> pcTarget == $past(pcTarget))
    else $error("return changed pc");
  timeoutSet_a: assert property (@(posedge clk) disable iff (!nrst)
    sWdtClear |=> status[4] && status[3])
    else $error("wdt clear flags wrong");
  sleepFlags_a: assert property (@(posedge clk) disable iff (!nrst)
    events.sleepInstr && !events.wdtClearInstr && !events.wdtTimeout && !events.extResetWake
    |=> status[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdtTimeout_a: assert property (@(posedge clk) disable iff (!nrst)
    events.wdtTimeout |=> !status[4])
    else $error("timeout flag not cleared");
  carryFlag_a: assert property (@(posedge clk) disable iff (!nrst)
    alu.carrySet |=> status[0] == $past(alu.carryVal))
    else $error("carry flag wrong");
  indirectAddr_a: assert property (@(posedge clk) disable iff (!nrst)
    access.addr == 6'h00 |-> decode.addr == pointer[5:0])
    else $error("indirect redirect wrong");
  port5Unused_a: assert property (@(posedge clk) disable iff (!nrst)
    port5[3:1] == 3'h0 && rdData[3:1] == 3'h0 || decode.addr != 6'h05)
    else $error("port 5 unused bits set");
endmodule // csb_core_status

// ---- verification/core_status_and_bank_select_tb.sv ----
`timescale 1ns/1ps
module core_status_and_bank_select_tb import csb_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0;
  csb_access_type access;
  csb_event_type  events;
  csb_alu_type    alu = '0;
  csb_decode_type decode;
  logic [9:0]  pcLow = '0;
  logic [12:0] pcTarget;
  logic [7:0]  rdData, pIn[4], pOut[4], pDir[4];
  logic [2:0]  romPage, pg;
  logic        rdHit;
  logic [31:0] seed = 32'h84f1, r;
  logic [7:0]  d;
  int          fails = 0, n_tests = 0;
  logic [5:0]  evs[5] = '{6'h20, 6'h08, 6'h10, 6'h08, 6'h04};
  logic [1:0]  tps[5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h2};
  initial forever #4 clk = ~clk;
  initial foreach (pIn[i]) begin pIn[i] = 8'h00; pDir[i] = 8'h00; end
  csb_core_model i_csb_core_model (.clk(clk), .access(access), .events(events));
  csb_core_status i_csb_core_status (.clk(clk), .nrst(nrst), .access(access),
    .rdData(rdData), .rdHit(rdHit), .decode(decode), .events(events), .alu(alu),
    .pcLow(pcLow), .pcTarget(pcTarget), .romPage(romPage),
    .portFiveIn(pIn[0]), .portSixIn(pIn[1]), .portSevenIn(pIn[2]),
    .portEightIn(pIn[3]), .portFiveOut(pOut[0]), .portSixOut(pOut[1]),
    .portSevenOut(pOut[2]), .portEightOut(pOut[3]), .portFiveDirCtrl(pDir[0]),
    .portSixDirCtrl(pDir[1]), .portSevenDirCtrl(pDir[2]),
    .portEightDirCtrl(pDir[3]));
  // ==========
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [2:0] fold(input logic [2:0] c);
    return (c > 3'h4) ? 3'h5 : c;
  endfunction
  task check(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdChk(input logic [5:0] a, input logic [7:0] exp);
    i_csb_core_model.rd(a);
    check(rdData, exp);
    check(rdHit, 1'b1);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Ceiling well above the 170 or so cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  // ==========
  // Scenarios
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    rdChk(6'h03, 8'h18);
    rdChk(6'h04, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      pg = i[2:0];
      d = {pg, r[4:0]};
      i_csb_core_model.wr(6'h03, d);
      rdChk(6'h03, d);
      check(romPage, fold(pg));
      @(negedge clk) pcLow = r[17:8];
      i_csb_core_model.ev(6'h02);
      check(pcTarget, {fold(pg), r[17:8]});
      i_csb_core_model.ev(6'h03);
      check(pcTarget, {fold(pg), r[17:8]});
      check(romPage, fold(pg));
    end
    $display("page test done");
    foreach (evs[i]) begin
      i_csb_core_model.ev(evs[i]);
      i_csb_core_model.rd(6'h03);
      check(rdData[4:3], tps[i]);
    end
    $display("event flag test done");
    for (int b = 0; b < 4; b++) begin
      r = rnd();
      d = {b[1:0], r[5:0]};
      i_csb_core_model.wr(6'h04, d);
      rdChk(6'h04, d);
      i_csb_core_model.rd(6'h20);
      check({decode.specialBank, decode.ramBank}, {b == 1, b[1:0]});
      check(decode.region, CSB_REGION_RAM);
      i_csb_core_model.rd(6'h00);
      check(decode.addr, d[5:0]);
    end
    foreach (evs[i]) begin
      i_csb_core_model.rd(i == 0 ? 6'h01 : i == 1 ? 6'h0a : 6'h15);
      check(decode.region, i == 0 ? CSB_REGION_COMMON : i == 1 ? CSB_REGION_SPECIAL
        : CSB_REGION_GENERAL);
      check(rdHit, 1'b0);
      check(rdData, 8'h00);
      if (i == 2) break;
    end
    $display("bank decode test done");
    i_csb_core_model.wr(6'h04, 8'h00);
    for (int a = 5; a < 9; a++) begin
      d = rnd();
      i_csb_core_model.wr(a[5:0], d);
      rdChk(a[5:0], a == 5 ? (d & 8'hf1) : d);
      check(pOut[a-5], a == 5 ? (d & 8'hf1) : d);
      if (a == 5) check(decode.ctrlPage, d[0]);
    end
    // Bank 1 hides the port registers, so this write must be dropped
    i_csb_core_model.wr(6'h04, 8'h40);
    i_csb_core_model.wr(6'h08, ~d);
    i_csb_core_model.wr(6'h04, 8'h00);
    rdChk(6'h08, d);
    r = rnd();
    @(negedge clk) begin pDir[1] = 8'hff; pIn[1] = r[7:0]; end
    repeat (3) @(negedge clk);
    rdChk(6'h06, r[7:0]);
    $display("port test done");
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      i_csb_core_model.wr(6'h03, 8'h00);
      @(negedge clk) alu = {r[3], r[2], r[4], r[1], r[5], r[0]};
      @(negedge clk) alu = '0;
      i_csb_core_model.rd(6'h03);
      check(rdData[2:0], {r[3] & r[2], r[4] & r[1], r[5] & r[0]});
    end
    $display("flag strobe test done");
    tally_and_finish;
  end
endmodule // core_status_and_bank_select_tb

// ---- verification/csb_core_model.sv ----
`timescale 1ns/1ps
module csb_core_model import csb_pkg::*; (
  // Clock
  input  wire logic     clk,
  // Instruction datapath side
  output csb_access_type access,
  output csb_event_type  events
);
  // ==========
  // Core cycles, launched on the falling edge
  initial begin
    access = '0;
    events = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk) access = '{1'b1, 1'b0, a, d};
    @(negedge clk) access = '0;
  endtask
  // Read stays up so the bench samples settled data
  task automatic rd(input logic [5:0] a);
    @(negedge clk) access = '{1'b0, 1'b1, a, 8'h00};
    #1;
  endtask
  // One-cycle event pulse
  task automatic ev(input logic [5:0] e);
    @(negedge clk) events = csb_event_type'(e);
    @(negedge clk) events = '0;
  endtask
endmodule // csb_core_model
